/* File: verilog/qrp_pkg.sv */
// shared constants and types for the quad mode read parameter block
package qrp_pkg;
	localparam logic [7:0] OP_UID = 8'h4B;
	localparam logic [7:0] OP_PARAM = 8'hC0;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_QIO = 8'hEB;
	localparam logic [7:0] OP_WRAP_RD = 8'h0C;
	localparam logic [7:0] OP_QPI_ON = 8'h38;
	localparam logic [7:0] OP_QPI_OFF = 8'hFF;
	localparam logic [7:0] OP_SET_WRAP = 8'h77;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam int P_DUMMY_LSB = 4;
	localparam int P_WRAP_LSB = 0;
	localparam int W_WRAP_LSB = 5;
	localparam logic [5:0] UID_DUMMY_BITS = 6'h20;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam logic [5:0] SET_WRAP_BITS = 6'h20;
	localparam logic [3:0] SR3_ZERO_DUMMY = 4'h8;
	localparam logic [1:0] REG_CFG = 2'h0;
	localparam logic [1:0] REG_FLAGS = 2'h1;
	localparam logic [1:0] REG_STATE = 2'h2;
	localparam int CFG_QE_BIT = 0;
	localparam int CFG_SR3_LSB = 4;
	localparam int ST_QPI_BIT = 0;
	localparam int ST_DUMMY_LSB = 1;
	localparam int ST_WRAP_LSB = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [1:0] FLAGS_RESET = 2'h0;
	// arbitrary value, stands in for the factory number
	localparam logic [63:0] UNIQUE_ID_DEFAULT = 64'h0123_4567_89AB_CDEF;
	typedef struct packed {
		logic [1:0] dummy_count_field;
		logic [1:0] wrap_length_field;
	} read_param_t;
	localparam read_param_t PARAM_RESET = '{dummy_count_field: 2'h0, wrap_length_field: 2'h0};
	typedef enum {ST_OP, ST_ADDR, ST_DUMMY, ST_DATA, ST_PARAM, ST_WRAPSET, ST_UIDDUM, ST_UIDOUT, ST_SKIP} state_t;
	function automatic logic [3:0] dummy_clocks(input logic [1:0] f);
		dummy_clocks = {1'b0, f, 1'b0} + 4'h2;
	endfunction : dummy_clocks
endpackage : qrp_pkg

/* File: verilog/read_param_store.sv */
// holds the dummy count and wrap length settings
`timescale 1ns/1ns
`default_nettype none
module read_param_store (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load_qpi,
	input wire logic load_wrap,
	input wire logic defaults,
	input wire logic [7:0] data,
	output qrp_pkg::read_param_t param
);
	// one wrap field serves both modes, so mode changes by 38h and FFh never touch it; the reset opcode (defaults) clears it
	always_ff @(posedge clk)
	begin
		if (!rst_n || defaults)
			param <= qrp_pkg::PARAM_RESET;
		else if (load_qpi)
			param <= '{dummy_count_field: data[qrp_pkg::P_DUMMY_LSB +: 2],
				wrap_length_field: data[qrp_pkg::P_WRAP_LSB +: 2]};
		else if (load_wrap)
			param.wrap_length_field <= data[qrp_pkg::W_WRAP_LSB +: 2];
	end

	a_param_default: assert property (@(posedge clk) !rst_n |=> param == qrp_pkg::PARAM_RESET)
		else $error("read parameters not at default after reset");
	a_param_load: assert property (@(posedge clk) disable iff (!rst_n)
		load_qpi && !defaults |=> param.dummy_count_field == $past(data[qrp_pkg::P_DUMMY_LSB +: 2])
		&& param.wrap_length_field == $past(data[qrp_pkg::P_WRAP_LSB +: 2]))
		else $error("read parameter load lost");
endmodule : read_param_store
`default_nettype wire

/* File: verilog/wrap_addr_step.sv */
// next byte address, wrapping inside the window when asked
`timescale 1ns/1ns
`default_nettype none
module wrap_addr_step (
	input wire logic [23:0] addr,
	input wire logic wrap_en,
	input wire logic [1:0] wrap_length_field,
	output logic [23:0] next_addr,
	output logic [23:0] mask
);
	wire [23:0] inc = addr + 24'h000001;
	// window of 8, 16, 32 or 64 bytes
	assign mask = (24'h000008 << wrap_length_field) - 24'h000001;
	assign next_addr = wrap_en ? ((addr & ~mask) | (inc & mask)) : inc;
endmodule : wrap_addr_step
`default_nettype wire

/* File: verilog/quad_read_control.sv */
// serial flash command decoder for unique id, read parameters, wrap burst and quad mode
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - 4Bh, four dummy bytes, then 64-bit id
// - unique id is constant, never writable
// - C0h refused in serial mode
// - C0h sets dummies and wrap in quad
// - serial modes take dummies from register three
// - 77h sets wrap in serial only; kept across modes
// - defaults: 8-byte wrap, 2 dummies
// - 0Ch wraps address inside window
// - only 38h enters quad mode
// - 38h ignored while quad enable clear
// - starts in serial mode after power-up
// - entry keeps latch, suspend, wrap
// - FFh in quad returns to serial
// - exit keeps latch, suspend, wrap
// - opcodes accepted only in their mode
module quad_read_control #(
	// arbitrary value, stands in for the factory number
	parameter logic [63:0] UNIQUE_ID = qrp_pkg::UNIQUE_ID_DEFAULT
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic [3:0] IO_I,
	output logic [3:0] IO_O,
	output logic [3:0] IO_OE,
	output logic [23:0] ARRAY_ADDR,
	input wire logic [7:0] ARRAY_DATA,
	input wire logic [1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA
);
	qrp_pkg::state_t state;
	qrp_pkg::state_t next_state;
	qrp_pkg::read_param_t param;
	logic sck_q;
	logic quad_peripheral_mode;
	logic quad_lanes;
	logic wrap_en;
	logic [7:0] rx;
	logic [7:0] tx;
	logic [23:0] addr;
	logic [5:0] cnt;
	logic [2:0] obit;
	logic [63:0] uid_sr;
	logic [7:0] cfg;
	logic [1:0] flags;

	// pins are synchronous to the system clock, so the serial clock is just sampled
	wire rise = SCK & ~sck_q & ~CS_N;
	wire fall = ~SCK & sck_q & ~CS_N;
	wire quad_enable_bit = cfg[qrp_pkg::CFG_QE_BIT];
	wire [3:0] status_register_three = cfg[qrp_pkg::CFG_SR3_LSB +: 4];
	wire write_enable_latch = flags[0];

	// input width: nibbles in quad mode, and for the quad io address phase
	wire in_wide = quad_peripheral_mode | (quad_lanes & (state == qrp_pkg::ST_ADDR));
	wire [5:0] step = (state == qrp_pkg::ST_DUMMY) ? 6'h01 : (in_wide ? 6'h04 : 6'h01);
	wire [5:0] next_cnt = cnt + step;
	wire [7:0] next_rx = in_wide ? {rx[3:0], IO_I} : {rx[6:0], IO_I[0]};
	wire [23:0] next_addr_sr = in_wide ? {addr[19:0], IO_I} : {addr[22:0], IO_I[0]};
	wire byte_done = rise && (next_cnt[2:0] == 3'h0);
	wire op_done = (state == qrp_pkg::ST_OP) && byte_done;
	wire [7:0] op = next_rx;

	// mode changes, each only from the mode it leaves
	wire qpi_enter = op_done && (op == qrp_pkg::OP_QPI_ON) && !quad_peripheral_mode && quad_enable_bit;
	wire qpi_leave = op_done && (op == qrp_pkg::OP_QPI_OFF) && quad_peripheral_mode;
	wire op_reset = op_done && (op == qrp_pkg::OP_RESET);
	wire param_load = (state == qrp_pkg::ST_PARAM) && byte_done && quad_peripheral_mode;
	wire wrapset_load = (state == qrp_pkg::ST_WRAPSET) && rise && (next_cnt == qrp_pkg::SET_WRAP_BITS);

	// dummy count: quad setting in quad mode, register three otherwise
	wire [3:0] sr3_dummy = (status_register_three == 4'h0) ? qrp_pkg::SR3_ZERO_DUMMY : status_register_three;
	wire [3:0] dummy_need = quad_peripheral_mode ? qrp_pkg::dummy_clocks(param.dummy_count_field) : sr3_dummy;
	wire dummy_last = rise && ((cnt + 6'h01) == {2'h0, dummy_need});

	// output side
	wire out_wide = quad_peripheral_mode | quad_lanes;
	wire out_state = (state == qrp_pkg::ST_DATA) || (state == qrp_pkg::ST_UIDOUT);
	wire [7:0] src_byte = (state == qrp_pkg::ST_UIDOUT) ? uid_sr[63:56] : ARRAY_DATA;
	wire [7:0] cur = (obit == 3'h0) ? src_byte : tx;
	wire [2:0] next_obit = obit + (out_wide ? 3'h4 : 3'h1);
	wire byte_end = fall && out_state && (next_obit == 3'h0);
	wire [23:0] step_addr;
	wire [23:0] wrap_mask;

	wire [7:0] rd_mux = (ADDR == qrp_pkg::REG_CFG) ? cfg :
		(ADDR == qrp_pkg::REG_FLAGS) ? {6'h00, flags} :
		(ADDR == qrp_pkg::REG_STATE) ? {3'h0, param.wrap_length_field, param.dummy_count_field, quad_peripheral_mode} :
		8'h00;

	read_param_store u_store (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.load_qpi(param_load),
		.load_wrap(wrapset_load),
		.defaults(op_reset),
		.data(next_rx),
		.param(param)
	);

	wrap_addr_step u_step (
		.addr(addr),
		.wrap_en(wrap_en & quad_peripheral_mode),
		.wrap_length_field(param.wrap_length_field),
		.next_addr(step_addr),
		.mask(wrap_mask)
	);

	always_comb
	begin
		next_state = state;
		case (state)
			qrp_pkg::ST_OP:
			begin
				if (op_done)
				begin
					case (op)
						qrp_pkg::OP_UID: next_state = qrp_pkg::ST_UIDDUM;
						qrp_pkg::OP_PARAM: next_state = quad_peripheral_mode ? qrp_pkg::ST_PARAM : qrp_pkg::ST_SKIP;
						qrp_pkg::OP_WRAP_RD: next_state = quad_peripheral_mode ? qrp_pkg::ST_ADDR : qrp_pkg::ST_SKIP;
						qrp_pkg::OP_FAST: next_state = qrp_pkg::ST_ADDR;
						qrp_pkg::OP_QIO: next_state = qrp_pkg::ST_ADDR;
						qrp_pkg::OP_SET_WRAP: next_state = quad_peripheral_mode ? qrp_pkg::ST_SKIP : qrp_pkg::ST_WRAPSET;
						default: next_state = qrp_pkg::ST_SKIP;
					endcase
				end
			end
			qrp_pkg::ST_ADDR:
			begin
				if (rise && (next_cnt == qrp_pkg::ADDR_BITS))
					next_state = qrp_pkg::ST_DUMMY;
			end
			qrp_pkg::ST_DUMMY:
			begin
				if (dummy_last)
					next_state = qrp_pkg::ST_DATA;
			end
			qrp_pkg::ST_PARAM:
			begin
				if (byte_done)
					next_state = qrp_pkg::ST_SKIP;
			end
			qrp_pkg::ST_WRAPSET:
			begin
				if (wrapset_load)
					next_state = qrp_pkg::ST_SKIP;
			end
			qrp_pkg::ST_UIDDUM:
			begin
				if (rise && (next_cnt == qrp_pkg::UID_DUMMY_BITS))
					next_state = qrp_pkg::ST_UIDOUT;
			end
			qrp_pkg::ST_DATA: next_state = state;
			qrp_pkg::ST_UIDOUT: next_state = state;
			qrp_pkg::ST_SKIP: next_state = state;
			default: next_state = qrp_pkg::ST_SKIP;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			sck_q <= 1'b0;
		else
			sck_q <= SCK;
	end

	// a deselect always ends the frame, whatever state it was in
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || CS_N)
		begin
			state <= qrp_pkg::ST_OP;
			cnt <= 6'h00;
		end
		else
		begin
			state <= next_state;
			if (next_state != state)
				cnt <= 6'h00;
			else if (rise)
				cnt <= next_cnt;
		end
	end

	// the mode bit is touched by 38h, FFh and the reset opcode only
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			quad_peripheral_mode <= 1'b0;
		else if (qpi_enter)
			quad_peripheral_mode <= 1'b1;
		else if (qpi_leave || op_reset)
			quad_peripheral_mode <= 1'b0;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			rx <= 8'h00;
			quad_lanes <= 1'b0;
			wrap_en <= 1'b0;
		end
		else
		begin
			if (rise)
				rx <= next_rx;
			if (op_done)
			begin
				quad_lanes <= (op == qrp_pkg::OP_QIO);
				wrap_en <= (op == qrp_pkg::OP_WRAP_RD);
			end
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			addr <= 24'h000000;
		else if ((state == qrp_pkg::ST_ADDR) && rise)
			addr <= next_addr_sr;
		else if (byte_end && (state == qrp_pkg::ST_DATA))
			addr <= step_addr;
	end

	// shift-out on falling serial clock edges, most significant first
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || CS_N)
		begin
			IO_O <= 4'h0;
			IO_OE <= 4'h0;
			tx <= 8'h00;
			obit <= 3'h0;
		end
		else if (fall && out_state)
		begin
			IO_O <= out_wide ? cur[7:4] : {2'h0, cur[7], 1'b0};
			IO_OE <= out_wide ? 4'hF : 4'h2;
			tx <= out_wide ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
			obit <= next_obit;
		end
	end

	// the id is only ever rotated, and reloaded from the constant between frames
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N || (state == qrp_pkg::ST_OP))
			uid_sr <= UNIQUE_ID;
		else if (byte_end && (state == qrp_pkg::ST_UIDOUT))
			uid_sr <= {uid_sr[55:0], uid_sr[63:56]};
	end

	// latch and suspend belong to software and the engines; mode changes never write them
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			cfg <= qrp_pkg::CFG_RESET;
			flags <= qrp_pkg::FLAGS_RESET;
			RDATA <= 8'h00;
		end
		else
		begin
			if (WR && (ADDR == qrp_pkg::REG_CFG))
				cfg <= WDATA;
			if (WR && (ADDR == qrp_pkg::REG_FLAGS))
				flags <= WDATA[1:0];
			RDATA <= RD ? rd_mux : 8'h00;
		end
	end

	assign ARRAY_ADDR = addr;

	a_qpi_entry_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$rose(quad_peripheral_mode) |-> $past(quad_enable_bit) && $past(op_done) && ($past(op) == qrp_pkg::OP_QPI_ON))
		else $error("quad mode entered without 38h and quad enable");
	a_qpi_exit_cmd: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		qpi_leave |=> !quad_peripheral_mode)
		else $error("FFh did not leave quad mode");
	a_start_serial: assert property (@(posedge CLK_SYS) !RST_N |=> !quad_peripheral_mode)
		else $error("quad mode active after reset");
	a_param_reject: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		op_done && !CS_N && (op == qrp_pkg::OP_PARAM) && !quad_peripheral_mode |=> state == qrp_pkg::ST_SKIP)
		else $error("C0h accepted in serial mode");
	a_mode_keeps_state: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(quad_peripheral_mode != $past(quad_peripheral_mode)) && !$past(op_reset)
		|-> (write_enable_latch == $past(write_enable_latch)) && (flags == $past(flags))
		&& (param.wrap_length_field == $past(param.wrap_length_field)))
		else $error("mode change disturbed latch, suspend or wrap");
	a_wrap_window: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		byte_end && (state == qrp_pkg::ST_DATA) && wrap_en && quad_peripheral_mode
		|=> (addr & ~wrap_mask) == ($past(addr) & ~$past(wrap_mask)))
		else $error("wrapped burst left its window");
	a_dummy_count: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$rose(state == qrp_pkg::ST_DATA) |-> ($past(cnt) + 6'h01) == {2'h0, $past(dummy_need)})
		else $error("data phase began after wrong dummy count");
	a_uid_start: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$rose(state == qrp_pkg::ST_UIDOUT) |-> $past(next_cnt) == qrp_pkg::UID_DUMMY_BITS)
		else $error("id shifted before four dummy bytes");
	a_quad_lanes: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		fall && out_state && quad_peripheral_mode && !CS_N |=> IO_OE == 4'hF)
		else $error("quad mode output not on four lines");
	a_uid_reload: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(state == qrp_pkg::ST_OP) |=> uid_sr == UNIQUE_ID)
		else $error("id not restored from the constant between frames");
	// serial mode has no path into the dummy field; only the reset opcode may move it there
	a_serial_dummy_kept: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		!quad_peripheral_mode && !op_reset |=> param.dummy_count_field == $past(param.dummy_count_field))
		else $error("dummy setting changed in serial mode");
	a_wrapset_serial: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		wrapset_load |-> !quad_peripheral_mode)
		else $error("serial wrap set taken in quad mode");
	a_serial_lane: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		fall && out_state && !quad_peripheral_mode && !quad_lanes |=> IO_OE == 4'h2)
		else $error("single lane output not on line one");
	// the last byte of a window must bring the address back to the window start
	a_wrap_return: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		byte_end && (state == qrp_pkg::ST_DATA) && wrap_en && quad_peripheral_mode
		&& ((addr & wrap_mask) == wrap_mask) |=> (addr & wrap_mask) == 24'h000000)
		else $error("wrapped burst did not return to window start");
	a_plain_step: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		byte_end && (state == qrp_pkg::ST_DATA) && !(wrap_en && quad_peripheral_mode)
		|=> addr == $past(addr) + 24'h000001)
		else $error("plain read did not step the address by one");
	a_param_defaults: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		op_reset |=> (param == qrp_pkg::PARAM_RESET) && !quad_peripheral_mode)
		else $error("reset opcode left settings or mode behind");
	a_dummy_decode: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		quad_peripheral_mode && (param.dummy_count_field == 2'h3) |-> dummy_need == 4'h8)
		else $error("largest dummy code not eight clocks");
	a_wrap_decode: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(param.wrap_length_field == 2'h3) |-> wrap_mask == 24'h00003F)
		else $error("largest wrap code not a 64-byte window");
endmodule : quad_read_control
`default_nettype wire

/* File: dv/host_model.sv */
// host side model: chip select, serial clock and data lines toward the block
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic [3:0] io,
	input wire logic [3:0] io_o
);
	initial
	begin
		cs_n = 1'h1;
		sck = 1'h0;
		io = 4'h0;
	end
	task automatic start();
		@(posedge clk);
		cs_n <= 1'h0;
	endtask : start
	// chip select rises first and the clock parks low after it, so the fall lands outside the frame
	task automatic stop();
		@(posedge clk);
		cs_n <= 1'h1;
		@(posedge clk);
		sck <= 1'h0;
		repeat (3) @(posedge clk);
	endtask : stop
	task automatic pulse(input logic [3:0] v);
		@(posedge clk);
		sck <= 1'h0;
		io <= v;
		@(posedge clk);
		@(posedge clk);
		sck <= 1'h1;
		@(posedge clk);
	endtask : pulse
	// msb first; quad sends the high nibble first
	task automatic shift(input logic [7:0] b, input logic q);
		int i;
		for (i = 7; i >= 0; i--)
			if (q && i % 4 == 3)
				pulse(b[i -: 4]);
			else if (!q)
				pulse({~{3{b[i]}}, b[i]});
	endtask : shift
	task automatic dummy(input int n);
		repeat (n) pulse(~io);
	endtask : dummy
	// lines released while the block talks: they toggle so a stale value cannot pass
	task automatic get(input logic q, output logic [7:0] b);
		int n;
		b = 8'h00;
		for (n = 0; n < (q ? 2 : 8); n++)
		begin
			@(posedge clk);
			sck <= 1'h0;
			io <= ~io;
			repeat (3) @(posedge clk);
			b = q ? {b[3:0], io_o} : {b[6:0], io_o[1]};
			sck <= 1'h1;
			@(posedge clk);
		end
	endtask : get
endmodule : host_model
`default_nettype wire

/* File: dv/tb_quad_read_control.sv */
// self-checking bench for the quad mode read parameter block
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module tb_quad_read_control;
	// arbitrary value, stands in for the factory number
	localparam logic [63:0] UID_VAL = 64'h5A3C_96F0_1E2D_4B87;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	wire logic cs_n, sck;
	wire logic [3:0] io_i, io_o, io_oe;
	wire logic [23:0] array_addr;
	wire logic [7:0] array_data, rdata;
	int n_fail = 0;
	int check_count = 0;
	logic [7:0] v;
	int d;
	assign array_data = array_addr[7:0] ^ 8'h5A;
	always #20 clk_sys = ~clk_sys;
	quad_read_control #(.UNIQUE_ID(UID_VAL)) u_quad_read_control (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.CS_N(cs_n), .SCK(sck), .IO_I(io_i), .IO_O(io_o), .IO_OE(io_oe), .ARRAY_ADDR(array_addr),
		.ARRAY_DATA(array_data), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
	host_model u_host (.clk(clk_sys), .cs_n(cs_n), .sck(sck), .io(io_i), .io_o(io_o));
	task automatic summarize();
		if (n_fail == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic wreg(input logic [1:0] a, input logic [7:0] x);
		@(posedge clk_sys);
		addr <= a;
		wdata <= x;
		wr <= 1'h1;
		@(posedge clk_sys);
		wr <= 1'h0;
	endtask : wreg
	task automatic rreg(input logic [1:0] a, output logic [7:0] x);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk_sys);
		rd <= 1'h0;
		@(negedge clk_sys);
		x = rdata;
	endtask : rreg
	function automatic logic [7:0] st(input logic q, input logic [1:0] dm, input logic [1:0] w);
		st = {3'h0, w, dm, q};
	endfunction : st
	task automatic st_is(input logic [7:0] e);
		logic [7:0] x;
		rreg(2'h2, x);
		`CHK("state", e, x)
	endtask : st_is
	task automatic cmd(input logic [7:0] op, input logic q, input int n, input logic [7:0] x);
		u_host.start();
		u_host.shift(op, q);
		repeat (n) u_host.shift(x, q);
		u_host.stop();
	endtask : cmd
	task automatic uid(input logic q);
		int k;
		logic [7:0] b;
		u_host.start();
		u_host.shift(8'h4B, q);
		u_host.dummy(q ? 8 : 32);
		for (k = 0; k < 8; k++)
		begin
			u_host.get(q, b);
			`CHK("uid", UID_VAL[8 * (7 - k) +: 8], b)
		end
		`CHK("uid lanes", q ? 4'hF : 4'h2, io_oe)
		u_host.stop();
	endtask : uid
	// wm marks the address bits that may move; the rest stay at the window start
	task automatic burst(input logic [7:0] op, input logic q, input logic [23:0] a, input int nd, input int nb,
		input logic [23:0] wm);
		int k;
		logic [7:0] b;
		logic [23:0] ea;
		u_host.start();
		u_host.shift(op, q);
		for (k = 2; k >= 0; k--)
			u_host.shift(a[8 * k +: 8], q);
		u_host.dummy(nd);
		for (k = 0; k < nb; k++)
		begin
			ea = (a & ~wm) | ((a + 24'(k)) & wm);
			u_host.get(q, b);
			`CHK("array", ea[7:0] ^ 8'h5A, b)
		end
		`CHK("array lanes", (q || op == 8'hEB) ? 4'hF : 4'h2, io_oe)
		u_host.stop();
	endtask : burst
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		// no write instruction is ever issued, so no power-up wait applies
		st_is(st(1'h0, 2'h0, 2'h0));
		rreg(2'h3, v);
		`CHK("unmapped", 8'h00, v)
		wreg(2'h2, 8'hFF);
		st_is(st(1'h0, 2'h0, 2'h0));
		cmd(8'h38, 1'h0, 0, 8'h00);
		st_is(st(1'h0, 2'h0, 2'h0));
		cmd(8'hC0, 1'h0, 1, 8'h33);
		st_is(st(1'h0, 2'h0, 2'h0));
		uid(1'h0);
		wreg(2'h0, 8'h41);
		burst(8'h0B, 1'h0, 24'h0000FE, 4, 3, 24'hFFFFFF);
		cmd(8'h77, 1'h0, 4, 8'h40);
		st_is(st(1'h0, 2'h0, 2'h2));
		wreg(2'h1, 8'h03);
		cmd(8'h38, 1'h0, 0, 8'h00);
		st_is(st(1'h1, 2'h0, 2'h2));
		rreg(2'h1, v);
		`CHK("flags", 8'h03, v)
		cmd(8'h77, 1'h1, 4, 8'h60);
		st_is(st(1'h1, 2'h0, 2'h2));
		for (d = 0; d < 4; d++)
		begin
			cmd(8'hC0, 1'h1, 1, {2'h0, 2'(d), 2'h0, 2'(d)});
			st_is(st(1'h1, 2'(d), 2'(d)));
		end
		cmd(8'hC0, 1'h1, 1, 8'h10);
		burst(8'h0C, 1'h1, 24'h000105, 4, 10, 24'h000007);
		cmd(8'hC0, 1'h1, 1, 8'h31);
		burst(8'h0C, 1'h1, 24'h00023E, 8, 18, 24'h00000F);
		burst(8'h0B, 1'h1, 24'h0001FF, 8, 2, 24'hFFFFFF);
		burst(8'hEB, 1'h1, 24'h000340, 8, 3, 24'hFFFFFF);
		uid(1'h1);
		cmd(8'hFF, 1'h1, 0, 8'h00);
		rreg(2'h2, v);
		`CHK("mode", 1'h0, v[0])
		`CHK("wrap", 2'h1, v[4:3])
		rreg(2'h1, v);
		`CHK("flags", 8'h03, v)
		cmd(8'h99, 1'h0, 0, 8'h00);
		st_is(st(1'h0, 2'h0, 2'h0));
		summarize();
	end
endmodule : tb_quad_read_control
`default_nettype wire
